// file: pkg/uvf_pkg.sv
/*
 * Constants shared by the sag force limit and overload protection logic.
 * Assumes a 40 MHz system clock and digitised bus voltage and current.
 */
package uvf_pkg;
    localparam int ClkHz = 40000000;
    localparam int MsPerSec = 1000;
    localparam int CyclesPerMs = ClkHz / MsPerSec;
    localparam logic [9:0] SagThresholdVolts = 10'd200;
    localparam logic [1:0] ModeOffRst = 2'h0;
    localparam logic [6:0] SagLimitRst = 7'd50;
    localparam logic [6:0] SagLimitMax = 7'd100;
    localparam logic [9:0] ReleaseMsRst = 10'd100;
    localparam logic [9:0] ReleaseMsMax = 10'd1000;
    localparam logic [6:0] WarnFracRst = 7'd20;
    localparam logic [6:0] DerateRst = 7'd100;
    localparam logic [6:0] DerateMin = 7'd10;
    localparam logic [6:0] FullPercent = 7'd100;

    typedef enum logic [1:0] {
        UVF_OFF = 2'b00,
        UVF_HOST = 2'b01,
        UVF_SELF = 2'b10
    } uvf_mode_e;

    typedef enum logic [1:0] {
        UVF_NORMAL = 2'b00,
        UVF_LIMIT = 2'b01,
        UVF_RELEASE = 2'b10
    } uvf_state_e;
endpackage

// file: verilog/uvf_protect.sv
/*
 * Sag force limiting and motor overload detection for a linear servo drive.
 * Assumes busVolts, motorCurrent and the settings come from asynchronous
 * sources; each is passed through two flip-flops before use.
 */
// What this block does
// - Flag low voltage when bus is at or below 200 V; limit current.
// - Low voltage only warns and limits; it never raises an alarm.
// - Independent mode: own limit on warning, released over set time.
// - Mode 0 off, 1 host limits, 2 internal limit; latched at restart.
// - Sag force limit 0..100 percent, default 50, applies immediately.
// - Release time 0..1000 ms, 1 ms steps, default 100, immediate.
// - Overload warning at set fraction of alarm time, 1..100, default 20.
// - Warning output asserts when overload warning detected.
// - Overload accumulation starts above base current times derating.
// - Derating 10..100 percent, default 100, latched at restart.
// - Derating shifts warning time since warning is fraction of alarm.
// - Instantaneous alarm uses fixed level, ignores warning and derating.
`timescale 1ns/1ps
module uvf_protect #(
    parameter int CurW = 16,
    parameter int AccW = 32,
    parameter logic [AccW-1:0] AlarmLevel = 32'd40000000,
    parameter int CyclesPerMs = uvf_pkg::CyclesPerMs
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Settings
    input wire logic [1:0] lowVoltageFunctionSetting,
    input wire logic [6:0] sagForceLimitSetting,
    input wire logic [9:0] sagLimitReleaseTime,
    input wire logic [6:0] overloadWarningFraction,
    input wire logic [6:0] baseCurrentDerating,
    // Measurements
    input wire logic [9:0] busVolts,
    input wire logic [CurW-1:0] motorCurrent,
    input wire logic [CurW-1:0] motorBaseCurrent,
    input wire logic [CurW-1:0] instantLevel,
    // Status toward the host
    output logic lowVoltWarn,
    output logic [6:0] forceLimitPct,
    output logic overloadWarn,
    output logic overloadAlarm,
    output logic instantAlarm
);
    logic [9:0] voltS1_q, voltS2_q;
    logic [CurW-1:0] curS1_q, curS2_q, baseS1_q, baseS2_q, instS1_q, instS2_q;
    logic [1:0] modeS1_q, modeS2_q;
    logic [6:0] limS1_q, limS2_q, fracS1_q, fracS2_q, derS1_q, derS2_q;
    logic [9:0] relS1_q, relS2_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            voltS1_q <= '0;
            voltS2_q <= '0;
            curS1_q <= '0;
            curS2_q <= '0;
            baseS1_q <= '0;
            baseS2_q <= '0;
            // Idle at the top of the range: zero current after reset
            // must not meet the level and trip the alarm at once.
            instS1_q <= '1;
            instS2_q <= '1;
            modeS1_q <= uvf_pkg::ModeOffRst;
            modeS2_q <= uvf_pkg::ModeOffRst;
            limS1_q <= uvf_pkg::SagLimitRst;
            limS2_q <= uvf_pkg::SagLimitRst;
            relS1_q <= uvf_pkg::ReleaseMsRst;
            relS2_q <= uvf_pkg::ReleaseMsRst;
            fracS1_q <= uvf_pkg::WarnFracRst;
            fracS2_q <= uvf_pkg::WarnFracRst;
            derS1_q <= uvf_pkg::DerateRst;
            derS2_q <= uvf_pkg::DerateRst;
        end else begin
            voltS1_q <= busVolts;
            voltS2_q <= voltS1_q;
            curS1_q <= motorCurrent;
            curS2_q <= curS1_q;
            baseS1_q <= motorBaseCurrent;
            baseS2_q <= baseS1_q;
            instS1_q <= instantLevel;
            instS2_q <= instS1_q;
            modeS1_q <= lowVoltageFunctionSetting;
            modeS2_q <= modeS1_q;
            limS1_q <= sagForceLimitSetting;
            limS2_q <= limS1_q;
            relS1_q <= sagLimitReleaseTime;
            relS2_q <= relS1_q;
            fracS1_q <= overloadWarningFraction;
            fracS2_q <= fracS1_q;
            derS1_q <= baseCurrentDerating;
            derS2_q <= derS1_q;
        end
    end

    // Clamp a percentage into a range.
    function automatic logic [6:0] clampPct(input logic [6:0] v,
                                            input logic [6:0] lo,
                                            input logic [6:0] hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // Restart-latched settings: captured on the third cycle after reset release,
    // after the synchronisers have filled.
    logic [1:0] latchCnt_q, latchCnt_d;
    logic [1:0] mode_q, mode_d;
    logic [6:0] derate_q, derate_d;

    always_comb begin
        latchCnt_d = latchCnt_q;
        mode_d = mode_q;
        derate_d = derate_q;
        if (latchCnt_q != 2'h3) begin
            latchCnt_d = latchCnt_q + 2'h1;
            if (latchCnt_q == 2'h2) begin
                // Illegal code 3 falls back to detection off.
                mode_d = (modeS2_q == 2'h3) ? uvf_pkg::ModeOffRst
                                            : modeS2_q;
                derate_d = clampPct(derS2_q, uvf_pkg::DerateMin,
                                    uvf_pkg::FullPercent);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latchCnt_q <= 2'h0;
            mode_q <= uvf_pkg::ModeOffRst;
            derate_q <= uvf_pkg::DerateRst;
        end else begin
            latchCnt_q <= latchCnt_d;
            mode_q <= mode_d;
            derate_q <= derate_d;
        end
    end

    // Sag detection and internal force limit.
    uvf_pkg::uvf_state_e state_q, state_d;
    logic warn_q, warn_d;
    logic [6:0] limit_q, limit_d;
    logic [6:0] step_q, step_d;
    logic [25:0] tick_q, tick_d;
    logic [9:0] msCnt_q, msCnt_d;
    logic [6:0] sagPct;
    logic [16:0] rampPct;
    logic sag;

    always_comb begin
        sagPct = clampPct(limS2_q, 7'h0, uvf_pkg::SagLimitMax);
        sag = (mode_q != uvf_pkg::UVF_OFF)
            && (voltS2_q <= uvf_pkg::SagThresholdVolts);
        state_d = state_q;
        tick_d = tick_q;
        msCnt_d = msCnt_q;
        step_d = step_q;
        // Warning only; no alarm is ever raised for a sag.
        warn_d = sag;
        rampPct = '0;
        limit_d = uvf_pkg::FullPercent;
        unique case (state_q)
            uvf_pkg::UVF_NORMAL: begin
                if (sag && mode_q == uvf_pkg::UVF_SELF) begin
                    state_d = uvf_pkg::UVF_LIMIT;
                end
            end
            uvf_pkg::UVF_LIMIT: begin
                limit_d = sagPct;
                if (!sag) begin
                    state_d = uvf_pkg::UVF_RELEASE;
                    step_d = sagPct;
                    tick_d = '0;
                    msCnt_d = '0;
                end
            end
            uvf_pkg::UVF_RELEASE: begin
                if (sag) begin
                    state_d = uvf_pkg::UVF_LIMIT;
                    limit_d = sagPct;
                end else if (msCnt_q >= relS2_q
                             || relS2_q > uvf_pkg::ReleaseMsMax) begin
                    state_d = uvf_pkg::UVF_NORMAL;
                end else begin
                    // Linear ramp from the clamped value to full.
                    rampPct = 17'(step_q) + 17'((17'(uvf_pkg::FullPercent
                        - step_q) * 17'(msCnt_q)) / 17'(relS2_q));
                    limit_d = rampPct[6:0];
                    if (tick_q == 26'(CyclesPerMs - 1)) begin
                        tick_d = '0;
                        msCnt_d = msCnt_q + 10'h1;
                    end else begin
                        tick_d = tick_q + 26'h1;
                    end
                end
            end
            default: state_d = uvf_pkg::UVF_NORMAL;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= uvf_pkg::UVF_NORMAL;
            warn_q <= 1'b0;
            limit_q <= uvf_pkg::FullPercent;
            step_q <= '0;
            tick_q <= '0;
            msCnt_q <= '0;
        end else begin
            state_q <= state_d;
            warn_q <= warn_d;
            limit_q <= limit_d;
            step_q <= step_d;
            tick_q <= tick_d;
            msCnt_q <= msCnt_d;
        end
    end

    // Overload accumulation. Above the derated base current the excess is
    // integrated; below it the accumulator bleeds down by the deficit.
    logic [AccW-1:0] acc_q, acc_d;
    logic olWarn_q, olWarn_d, olAlarm_q, olAlarm_d, inst_q, inst_d;
    logic [CurW+6:0] deratedBase;
    logic [AccW+6:0] warnLevel;
    logic [6:0] fracPct;

    always_comb begin
        deratedBase = ((CurW+7)'(baseS2_q) * (CurW+7)'(derate_q))
            / (CurW+7)'(uvf_pkg::FullPercent);
        fracPct = clampPct(fracS2_q, 7'h1, uvf_pkg::FullPercent);
        // Warning level is a fraction of AlarmLevel on the same accumulator,
        // so derating moves the warning as well.
        warnLevel = ((AccW+7)'(AlarmLevel) * (AccW+7)'(fracPct))
            / (AccW+7)'(uvf_pkg::FullPercent);
        acc_d = acc_q;
        if ((CurW+7)'(curS2_q) > deratedBase) begin
            if (acc_q < AlarmLevel) begin
                acc_d = acc_q + AccW'((CurW+7)'(curS2_q) - deratedBase);
            end
        end else if (acc_q > AccW'(deratedBase - (CurW+7)'(curS2_q))) begin
            acc_d = acc_q - AccW'(deratedBase - (CurW+7)'(curS2_q));
        end else begin
            acc_d = '0;
        end
        olWarn_d = (AccW+7)'(acc_q) >= warnLevel;
        olAlarm_d = olAlarm_q || (acc_q >= AlarmLevel);
        // Fixed level, independent of both settings.
        inst_d = inst_q || (curS2_q >= instS2_q);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
            olWarn_q <= 1'b0;
            olAlarm_q <= 1'b0;
            inst_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            olWarn_q <= olWarn_d;
            olAlarm_q <= olAlarm_d;
            inst_q <= inst_d;
        end
    end

    assign lowVoltWarn = warn_q;
    assign forceLimitPct = limit_q;
    assign overloadWarn = olWarn_q;
    assign overloadAlarm = olAlarm_q;
    assign instantAlarm = inst_q;
endmodule // uvf_protect

// file: dv/uvf_protect_monitor.sv
/* Checker for the ports of uvf_protect.
   Assumes mode and derating settings change only while rst is high. */
`timescale 1ns/1ps
module uvf_protect_monitor #(
    parameter int CurW = 16,
    parameter int CyclesPerMs = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] lowVoltageFunctionSetting,
    input wire logic [6:0] sagForceLimitSetting,
    input wire logic [9:0] sagLimitReleaseTime,
    input wire logic [6:0] overloadWarningFraction,
    input wire logic [9:0] busVolts,
    input wire logic [CurW-1:0] motorCurrent,
    input wire logic [CurW-1:0] instantLevel,
    input wire logic lowVoltWarn,
    input wire logic [6:0] forceLimitPct,
    input wire logic overloadWarn,
    input wire logic overloadAlarm,
    input wire logic instantAlarm
);
    logic [19:0] relCnt_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Counts cycles spent below full force with the warning gone.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            relCnt_q <= 20'h0;
        end else if (lowVoltWarn || forceLimitPct == 7'h64) begin
            relCnt_q <= 20'h0;
        end else begin
            relCnt_q <= relCnt_q + 20'h1;
        end
    end

    sequence sagHeld;
        lowVoltWarn ##1 lowVoltWarn;
    endsequence
    sequence sagGone;
        !lowVoltWarn ##1 !lowVoltWarn;
    endsequence

    sag_level_a: assert property (
        lowVoltWarn |-> $past(busVolts, 3) <= 10'h0c8)
        else $error("warning without a sag");
    off_quiet_a: assert property (
        lowVoltageFunctionSetting == 2'h0 |-> !lowVoltWarn)
        else $error("warning while detection is off");
    host_full_a: assert property (
        lowVoltageFunctionSetting != 2'h2 |-> forceLimitPct == 7'h64)
        else $error("limit applied outside internal mode");
    sag_limit_a: assert property (
        (lowVoltageFunctionSetting == 2'h2) ##0 sagHeld
        |-> forceLimitPct == sagForceLimitSetting)
        else $error("sag limit not applied");
    limit_range_a: assert property (forceLimitPct <= 7'h64)
        else $error("limit above full force");
    ramp_rise_a: assert property (
        sagGone |-> forceLimitPct >= $past(forceLimitPct))
        else $error("limit fell during release");
    release_bound_a: assert property (
        int'(relCnt_q) <= int'(sagLimitReleaseTime) * CyclesPerMs + 8)
        else $error("release took too long");
    warn_first_a: assert property (
        $rose(overloadAlarm) && overloadWarningFraction < 7'h64
        |-> $past(overloadWarn))
        else $error("alarm without earlier warning");
    instant_level_a: assert property (
        $rose(instantAlarm)
        |-> $past(motorCurrent, 3) >= $past(instantLevel, 3))
        else $error("instant alarm below its level");
    sag_no_alarm_a: assert property (
        $rose(lowVoltWarn)
        |-> !$rose(overloadAlarm) && !$rose(instantAlarm))
        else $error("sag raised an alarm");
endmodule // uvf_protect_monitor

bind uvf_protect uvf_protect_monitor #(
    .CurW(CurW),
    .CyclesPerMs(CyclesPerMs)
) u_uvf_protect_monitor (
    .clk,
    .rst,
    .lowVoltageFunctionSetting,
    .sagForceLimitSetting,
    .sagLimitReleaseTime,
    .overloadWarningFraction,
    .busVolts,
    .motorCurrent,
    .instantLevel,
    .lowVoltWarn,
    .forceLimitPct,
    .overloadWarn,
    .overloadAlarm,
    .instantAlarm
);

// file: dv/uvf_host_model.sv
/* Host controller stand-in that lowers its force reference on warning.
   Assumes warning and limit come straight from uvf_protect. */
`timescale 1ns/1ps
module uvf_host_model #(
    parameter logic [6:0] ReducePct = 7'h28
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // From the drive
    input wire logic lowVoltWarn,
    input wire logic [6:0] forceLimitPct,
    // Force reference
    output logic [6:0] hostForceRef
);
    logic [6:0] forceRef_d;
    logic [6:0] forceRef_q;

    always_comb begin
        forceRef_d = lowVoltWarn ? ReducePct : 7'h64;
        // Never ask for more than the drive allows when power returns.
        if (forceRef_d > forceLimitPct) begin
            forceRef_d = forceLimitPct;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            forceRef_q <= 7'h64;
        end else begin
            forceRef_q <= forceRef_d;
        end
    end

    assign hostForceRef = forceRef_q;
endmodule // uvf_host_model

// file: dv/uvf_protect_test.sv
/* Self-checking bench for uvf_protect with a host model.
   Assumes the short sim values AlarmLevel 1000 and CyclesPerMs 4. */
`timescale 1ns/1ps
module uvf_protect_test;
    logic clk, rst, lowVoltWarn, overloadWarn, overloadAlarm, instantAlarm;
    logic [1:0] mode;
    logic [6:0] sagPct, warnFrac, derate, forceLimitPct, hostForceRef;
    logic [9:0] relMs, busV;
    logic [15:0] cur, baseCur, instLvl;
    int nFail = 0;
    int samplesChecked = 0;
    int n, w;
    int runs [3][3] = '{'{50, 20, 8}, '{100, 20, 16}, '{50, 50, 5}};

    uvf_protect #(.AlarmLevel(32'd1000), .CyclesPerMs(4)) u_uvf_protect (
        .clk, .rst, .lowVoltageFunctionSetting(mode),
        .sagForceLimitSetting(sagPct), .sagLimitReleaseTime(relMs),
        .overloadWarningFraction(warnFrac), .baseCurrentDerating(derate),
        .busVolts(busV), .motorCurrent(cur), .motorBaseCurrent(baseCur),
        .instantLevel(instLvl), .lowVoltWarn, .forceLimitPct, .overloadWarn,
        .overloadAlarm, .instantAlarm);
    uvf_host_model u_uvf_host_model (.clk, .rst, .lowVoltWarn,
        .forceLimitPct, .hostForceRef);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic conclude();
        if (nFail == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chkPct(input logic [6:0] got, input logic [6:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        chkPct({6'h0, got}, {6'h0, exp});
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic restart(input logic [1:0] m, input logic [6:0] d);
        rst <= 1'b1;
        mode <= m;
        derate <= d;
        cyc(3);
        rst <= 1'b0;
        cyc(5);
    endtask
    // Bounded wait; sel 0 warning, 1 overload alarm, 2 instant alarm.
    task automatic waitHigh(input int sel, output int k);
        k = 0;
        while ((sel == 0 ? overloadWarn : sel == 1 ? overloadAlarm
                : instantAlarm) !== 1'b1) begin
            cyc(1);
            k++;
            if (k > 300) begin
                nFail++;
                conclude();
            end
        end
    endtask

    initial begin
        rst <= 1'b1;
        mode <= 2'h0;
        sagPct <= 7'h1e;
        relMs <= 10'h00a;
        warnFrac <= 7'h14;
        derate <= 7'h64;
        busV <= 10'h12c;
        cur <= 16'h0000;
        baseCur <= 16'h0064;
        instLvl <= 16'hffff;
        // Code 3 is illegal and must behave as detection off.
        for (int m = 0; m < 4; m++) begin
            restart(m[1:0], 7'h64);
            chkPct(forceLimitPct, 7'h64);
            busV <= 10'h0c9;
            cyc(8);
            chkBit(lowVoltWarn, 1'b0);
            busV <= 10'h0c8;
            cyc(8);
            chkBit(lowVoltWarn, m == 1 || m == 2);
            chkPct(forceLimitPct, m == 2 ? sagPct : 7'h64);
            chkPct(hostForceRef,
                   m == 1 ? 7'h28 : m == 2 ? sagPct : 7'h64);
            busV <= 10'h12c;
            cyc(21);
            chkBit(lowVoltWarn, 1'b0);
            if (m == 2) begin
                chkBit(forceLimitPct > sagPct
                       && forceLimitPct < 7'h64, 1'b1);
                sagPct <= 7'h46;
                busV <= 10'h0c8;
                cyc(8);
                chkPct(forceLimitPct, 7'h46);
                // A full release with the ten millisecond setting.
                busV <= 10'h12c;
                cyc(24);
                chkBit(forceLimitPct > 7'h46
                       && forceLimitPct < 7'h64, 1'b1);
                cyc(24);
                chkPct(forceLimitPct, 7'h64);
                busV <= 10'h0c8;
                cyc(8);
                relMs <= 10'h000;
                busV <= 10'h12c;
                cyc(7);
            end
            cyc(44);
            chkPct(forceLimitPct, 7'h64);
        end
        for (int r = 0; r < 3; r++) begin
            warnFrac <= runs[r][1][6:0];
            restart(2'h0, runs[r][0][6:0]);
            cur <= 16'h0096;
            waitHigh(0, w);
            chkBit(overloadAlarm, 1'b0);
            waitHigh(1, n);
            chkBit(n >= runs[r][2] - 2
                   && n <= runs[r][2] + 2, 1'b1);
            cur <= 16'h0000;
        end
        restart(2'h0, 7'h64);
        instLvl <= 16'h01f4;
        cur <= 16'h01f3;
        cyc(8);
        chkBit(instantAlarm, 1'b0);
        cur <= 16'h01f4;
        waitHigh(2, n);
        chkBit(n <= 6, 1'b1);
        conclude();
    end
endmodule // uvf_protect_test
